// *** src/t1_performance_monitor_map.svh ***
// register indices, field positions and reset values of the counter bank
`ifndef T1_PERFORMANCE_MONITOR_MAP_SVH
`define T1_PERFORMANCE_MONITOR_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define PM_IDX_W          14
`define PM_IDX_PRBS_HIGH  14'h090d
`define PM_IDX_PRBS_LOW   14'h090e
`define PM_IDX_SLIP       14'h090f
`define PM_IDX_ZERO_HIGH  14'h0910
`define PM_IDX_ZERO_LOW   14'h0911
`define PM_IDX_IRQ_STATUS 14'h0920
`define PM_IDX_IRQ_MASK   14'h0921

// ----------------------------------------------------------------
// event bit positions in status and mask
// ----------------------------------------------------------------
`define PM_EV_PRBS  0
`define PM_EV_SLIP  1
`define PM_EV_ZERO  2
`define PM_EV_COUNT 3

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define PM_PRBS_W    16
`define PM_SLIP_W    8
`define PM_ZERO_W    16
`define PM_BYTE_RST  8'h00
`define PM_MASK_RST  3'h0

`endif

// *** src/t1_performance_monitor_pkg.sv ***
// types shared by the counter bank modules
package t1_performance_monitor_pkg;

  // events from the receive framer and the transmit slip buffer
  typedef struct packed {
    logic prbs_bit_error;
    logic slip_frame_repeat;
    logic slip_frame_drop;
    logic zero_run_violation;
  } performance_monitor_events_t;

  // state of the bus-facing part of the bank
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  prbs_shadow;
    logic        prbs_vld;
    logic [7:0]  zero_shadow;
    logic        zero_vld;
    logic [2:0]  mask;
  } bank_state_t;

  typedef struct packed {
    logic [2:0] status;
    logic       irq;
  } irq_state_t;

endpackage

// *** src/tally_counter.sv ***
// saturating event counter with clear that keeps a same-cycle event
`timescale 1ns/1ps
`default_nettype none
module tally_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [1:0]       inc_i,
  input  wire logic             clear_i,
  output logic      [WIDTH-1:0] count_o
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tally_state_t;

  tally_state_t st_r;
  tally_state_t st_nxt;

  // add, stopping at all ones
  function automatic logic [WIDTH-1:0] sat_add(input logic [WIDTH-1:0] b,
                                               input logic [1:0] inc);
    logic [WIDTH:0] sum;
    sum = {1'b0, b} + {{(WIDTH-1){1'b0}}, inc};
    sat_add = sum[WIDTH] ? {WIDTH{1'b1}} : sum[WIDTH-1:0];
  endfunction

  always_comb begin
    st_nxt = st_r;
    // an event in the clearing cycle starts the next count
    st_nxt.count = sat_add(clear_i ? {WIDTH{1'b0}} : st_r.count, inc_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_o = st_r.count;

endmodule
`default_nettype wire

// *** src/irq_sticky.sv ***
// sticky event status, read-clear, masked onto one level interrupt
`timescale 1ns/1ps
`default_nettype none
module irq_sticky (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] set_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] mask_i,
  output logic      [2:0] status_o,
  output logic            irq_o
);

  t1_performance_monitor_pkg::irq_state_t st_r;
  t1_performance_monitor_pkg::irq_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // set wins over the read that clears
    st_nxt.status = (clear_i ? 3'h0 : st_r.status) | set_i;
    st_nxt.irq    = |(st_nxt.status & mask_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status_o = st_r.status;
  assign irq_o    = st_r.irq;

endmodule
`default_nettype wire

// *** src/t1_perf_error_counters.sv ***
// performance error counter bank with classic wishbone register port
`timescale 1ns/1ps
`default_nettype none
`include "t1_performance_monitor_map.svh"
module t1_perf_error_counters (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [15:0]               adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic                           ack_o,
  output logic      [31:0]               dat_o,
  input  wire t1_performance_monitor_pkg::performance_monitor_events_t events_i,
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  t1_performance_monitor_pkg::bank_state_t st_r;
  t1_performance_monitor_pkg::bank_state_t st_nxt;

  logic [`PM_IDX_W-1:0]  idx;
  logic                  go;
  logic                  rd;
  logic                  wr;
  logic                  rd_prbs_hi;
  logic                  rd_prbs_lo;
  logic                  rd_slip;
  logic                  rd_zero_hi;
  logic                  rd_zero_lo;
  logic                  rd_status;
  logic                  prbs_clr;
  logic                  slip_clr;
  logic                  zero_clr;
  logic [1:0]            prbs_inc;
  logic [1:0]            slip_inc;
  logic [1:0]            zero_inc;
  logic [2:0]            ev_set;
  logic [2:0]            status;
  logic [`PM_PRBS_W-1:0] prbs_cnt;
  logic [`PM_SLIP_W-1:0] slip_cnt;
  logic [`PM_ZERO_W-1:0] zero_cnt;

  // byte register onto the 32-bit data bus, upper bits zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // one access per request: the edge that raises ack does the side effect
  assign go  = cyc_i & stb_i & ~st_r.ack;
  assign idx = adr_i[15:2];
  assign rd  = go & ~we_i;
  assign wr  = go & we_i;

  assign rd_prbs_hi = rd & (idx == `PM_IDX_PRBS_HIGH);
  assign rd_prbs_lo = rd & (idx == `PM_IDX_PRBS_LOW);
  assign rd_slip    = rd & (idx == `PM_IDX_SLIP);
  assign rd_zero_hi = rd & (idx == `PM_IDX_ZERO_HIGH);
  assign rd_zero_lo = rd & (idx == `PM_IDX_ZERO_LOW);
  assign rd_status  = rd & (idx == `PM_IDX_IRQ_STATUS);

  // a low read after a high read only drains the shadow
  assign prbs_clr = rd_prbs_hi | (rd_prbs_lo & ~st_r.prbs_vld);
  assign zero_clr = rd_zero_hi | (rd_zero_lo & ~st_r.zero_vld);
  assign slip_clr = rd_slip;

  // ----------------------------------------------------------------
  // event inputs
  // ----------------------------------------------------------------
  // same clock as the framer core, so no synchroniser here
  assign prbs_inc = {1'b0, events_i.prbs_bit_error};
  assign zero_inc = {1'b0, events_i.zero_run_violation};
  // repeat and drop in one cycle are two slips
  assign slip_inc = {events_i.slip_frame_repeat & events_i.slip_frame_drop,
                     events_i.slip_frame_repeat ^ events_i.slip_frame_drop};

  assign ev_set[`PM_EV_PRBS] = events_i.prbs_bit_error;
  assign ev_set[`PM_EV_SLIP] = events_i.slip_frame_repeat | events_i.slip_frame_drop;
  assign ev_set[`PM_EV_ZERO] = events_i.zero_run_violation;

  // ----------------------------------------------------------------
  // counters and interrupt
  // ----------------------------------------------------------------
  tally_counter #(
    .WIDTH (`PM_PRBS_W)
  ) u_prbs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (prbs_inc),
    .clear_i (prbs_clr),
    .count_o (prbs_cnt)
  );

  tally_counter #(
    .WIDTH (`PM_SLIP_W)
  ) u_slip (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (slip_inc),
    .clear_i (slip_clr),
    .count_o (slip_cnt)
  );

  tally_counter #(
    .WIDTH (`PM_ZERO_W)
  ) u_zero (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .inc_i   (zero_inc),
    .clear_i (zero_clr),
    .count_o (zero_cnt)
  );

  irq_sticky u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .set_i    (ev_set),
    .clear_i  (rd_status),
    .mask_i   (st_r.mask),
    .status_o (status),
    .irq_o    (irq_o)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = go;
    if (go) begin
      st_nxt.dat = 32'h00000000;
    end
    if (rd) begin
      case (idx)
        `PM_IDX_PRBS_HIGH: begin
          st_nxt.dat         = byte_word(prbs_cnt[15:8]);
          st_nxt.prbs_shadow = prbs_cnt[7:0];
          st_nxt.prbs_vld    = 1'b1;
        end
        `PM_IDX_PRBS_LOW: begin
          if (st_r.prbs_vld) begin
            st_nxt.dat      = byte_word(st_r.prbs_shadow);
            st_nxt.prbs_vld = 1'b0;
          end else begin
            st_nxt.dat = byte_word(prbs_cnt[7:0]);
          end
        end
        `PM_IDX_SLIP: begin
          st_nxt.dat = byte_word(slip_cnt);
        end
        `PM_IDX_ZERO_HIGH: begin
          st_nxt.dat         = byte_word(zero_cnt[15:8]);
          st_nxt.zero_shadow = zero_cnt[7:0];
          st_nxt.zero_vld    = 1'b1;
        end
        `PM_IDX_ZERO_LOW: begin
          if (st_r.zero_vld) begin
            st_nxt.dat      = byte_word(st_r.zero_shadow);
            st_nxt.zero_vld = 1'b0;
          end else begin
            st_nxt.dat = byte_word(zero_cnt[7:0]);
          end
        end
        `PM_IDX_IRQ_STATUS: begin
          st_nxt.dat = {29'h00000000, status};
        end
        `PM_IDX_IRQ_MASK: begin
          st_nxt.dat = {29'h00000000, st_r.mask};
        end
        default: begin
          // unmapped: acknowledged, reads zero
          st_nxt.dat = 32'h00000000;
        end
      endcase
    end
    // only the mask is writable; writes to counters are dropped
    if (wr && (idx == `PM_IDX_IRQ_MASK) && sel_i[0]) begin
      st_nxt.mask = dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.mask <= `PM_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = st_r.ack;
  assign dat_o = st_r.dat;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence zero_hi_read;
    rd_zero_hi ##1 ack_o;
  endsequence

  sequence prbs_hi_read;
    rd_prbs_hi ##1 ack_o;
  endsequence

  AST_PRBS_INC: assert property (
    (events_i.prbs_bit_error && !prbs_clr && prbs_cnt != 16'hffff)
      |=> prbs_cnt == $past(prbs_cnt) + 16'h0001)
    else $error("prbs error not counted");

  AST_PRBS_CLR: assert property (
    prbs_clr |=> prbs_cnt == {15'h0000, $past(events_i.prbs_bit_error)})
    else $error("prbs count not cleared by read");

  AST_PRBS_LOW: assert property (
    (rd_prbs_lo && !st_r.prbs_vld)
      |=> ack_o && dat_o == byte_word($past(prbs_cnt[7:0])))
    else $error("prbs low byte wrong");

  AST_PRBS_HIGH: assert property (
    prbs_hi_read |-> dat_o == byte_word($past(prbs_cnt[15:8])))
    else $error("prbs high byte wrong");

  AST_SLIP_READ: assert property (
    rd_slip |=> dat_o == byte_word($past(slip_cnt))
                && slip_cnt == {6'h00, $past(slip_inc)})
    else $error("slip read or clear wrong");

  AST_SLIP_TWO: assert property (
    (!rd_slip && events_i.slip_frame_repeat && events_i.slip_frame_drop
     && slip_cnt < 8'hfd) |=> slip_cnt == $past(slip_cnt) + 8'h02)
    else $error("double slip not counted twice");

  AST_ZERO_INC: assert property (
    (events_i.zero_run_violation && !zero_clr && zero_cnt != 16'hffff)
      |=> zero_cnt == $past(zero_cnt) + 16'h0001)
    else $error("zero violation not counted");

  AST_ZERO_HIGH: assert property (
    zero_hi_read |-> dat_o == byte_word($past(zero_cnt[15:8])))
    else $error("zero high byte wrong");

  AST_ZERO_PAIR: assert property (
    zero_hi_read ##2 rd_zero_lo |=> dat_o == byte_word($past(zero_cnt[7:0], 4)))
    else $error("zero low byte not coherent with high read");

  AST_ZERO_KEEP: assert property (
    (rd_zero_hi && events_i.zero_run_violation) |=> zero_cnt == 16'h0001)
    else $error("event during read lost");

  AST_SAT_HOLD: assert property (
    (prbs_cnt == 16'hffff && !prbs_clr) |=> prbs_cnt == 16'hffff)
    else $error("prbs count wrapped");

  AST_SLIP_SAT: assert property (
    (slip_cnt == 8'hff && !slip_clr) |=> slip_cnt == 8'hff)
    else $error("slip count wrapped");

  AST_ZERO_SAT: assert property (
    (zero_cnt == 16'hffff && !zero_clr) |=> zero_cnt == 16'hffff)
    else $error("zero count wrapped");

  AST_SLIP_ONE: assert property (
    (!rd_slip && (events_i.slip_frame_repeat ^ events_i.slip_frame_drop)
     && slip_cnt != 8'hff) |=> slip_cnt == $past(slip_cnt) + 8'h01)
    else $error("single slip not counted once");

  AST_ZERO_CLR: assert property (
    zero_clr |=> zero_cnt == {15'h0000, $past(events_i.zero_run_violation)})
    else $error("zero count not cleared by read");

  AST_ZERO_LOW: assert property (
    (rd_zero_lo && !st_r.zero_vld)
      |=> ack_o && dat_o == byte_word($past(zero_cnt[7:0])))
    else $error("zero low byte wrong");

  AST_PRBS_PAIR: assert property (
    prbs_hi_read ##2 rd_prbs_lo |=> dat_o == byte_word($past(prbs_cnt[7:0], 4)))
    else $error("prbs low byte not coherent with high read");

  AST_PRBS_KEEP: assert property (
    (rd_prbs_hi && events_i.prbs_bit_error) |=> prbs_cnt == 16'h0001)
    else $error("prbs event during read lost");

  // a shadowed low read leaves the live count alone
  sequence prbs_lo_shadow_read;
    rd_prbs_lo && st_r.prbs_vld && prbs_cnt != 16'hffff;
  endsequence

  AST_PRBS_LOW_HOLD: assert property (
    prbs_lo_shadow_read
      |=> prbs_cnt == $past(prbs_cnt) + {15'h0000, $past(events_i.prbs_bit_error)})
    else $error("shadowed prbs low read touched the count");

  sequence zero_lo_shadow_read;
    rd_zero_lo && st_r.zero_vld && zero_cnt != 16'hffff;
  endsequence

  AST_ZERO_LOW_HOLD: assert property (
    zero_lo_shadow_read
      |=> zero_cnt == $past(zero_cnt) + {15'h0000, $past(events_i.zero_run_violation)})
    else $error("shadowed zero low read touched the count");

  // ----------------------------------------------------------------
  // bus and interrupt checks
  // ----------------------------------------------------------------
  sequence bus_request;
    cyc_i && stb_i && !ack_o;
  endsequence

  AST_ACK_ANSWER: assert property (
    bus_request |=> ack_o)
    else $error("request not acknowledged next cycle");

  AST_ACK_PULSE: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // mask changes reach the interrupt one cycle late
  AST_IRQ_LEVEL: assert property (
    $stable(st_r.mask) |-> irq_o == (|(status & st_r.mask)))
    else $error("interrupt level does not follow status and mask");

endmodule
`default_nettype wire

// *** testbench/t1_perf_error_counters_test.sv ***
// self-checking bench for the performance error counter bank
`timescale 1ns/1ps
`default_nettype none
`include "t1_performance_monitor_map.svh"
module t1_perf_error_counters_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                      clk_i;
  logic                      rst_i;
  logic                      cyc_i;
  logic                      stb_i;
  logic                      we_i;
  logic [15:0]               adr_i;
  logic [3:0]                sel_i;
  logic [31:0]               dat_i;
  logic                      ack_o;
  logic [31:0]               dat_o;
  t1_performance_monitor_pkg::performance_monitor_events_t events_i;
  logic                      irq_o;
  int                        n_errors;
  int                        checks;
  t1_performance_monitor_pkg::performance_monitor_events_t ev_prbs;
  t1_performance_monitor_pkg::performance_monitor_events_t ev_rep;
  t1_performance_monitor_pkg::performance_monitor_events_t ev_drop;
  t1_performance_monitor_pkg::performance_monitor_events_t ev_zero;

  t1_perf_error_counters dut (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .ack_o    (ack_o),
    .dat_o    (dat_o),
    .events_i (events_i),
    .irq_o    (irq_o)
  );

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic cycle; ack is taken at the edge where it is sampled high
  task automatic wb(input logic we, input logic [13:0] idx, input logic [3:0] sel,
                    input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= {idx, 2'b00};
    sel_i <= sel;
    dat_i <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (i == 20) begin
      n_errors++;
      $display("CHECK FAILED ack expected 1 seen none");
      final_report();
    end
  endtask

  task automatic rd_chk(input string name, input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, idx, 4'h0, 32'h0, rd);
    chk(name, exp, rd);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [3:0] sel, input logic [31:0] wd);
    logic [31:0] rd;
    wb(1'b1, idx, sel, wd, rd);
  endtask

  // v held for exactly n sampling edges
  task automatic ev(input t1_performance_monitor_pkg::performance_monitor_events_t v, input int n);
    @(posedge clk_i);
    events_i <= v;
    repeat (n) @(posedge clk_i);
    events_i <= '0;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq_o", {31'h0, exp}, {31'h0, irq_o});
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    checks   = 0;
    rst_i    = 1'b1;
    cyc_i    = 1'b0;
    stb_i    = 1'b0;
    we_i     = 1'b0;
    adr_i    = 16'h0000;
    sel_i    = 4'h0;
    dat_i    = 32'h0;
    events_i = '0;
    ev_prbs  = '0;
    ev_rep   = '0;
    ev_drop  = '0;
    ev_zero  = '0;
    ev_prbs.prbs_bit_error     = 1'b1;
    ev_rep.slip_frame_repeat   = 1'b1;
    ev_drop.slip_frame_drop    = 1'b1;
    ev_zero.zero_run_violation = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place reads zero
    rd_chk("prbs_high", `PM_IDX_PRBS_HIGH, 32'h0);
    rd_chk("prbs_low", `PM_IDX_PRBS_LOW, 32'h0);
    rd_chk("slip", `PM_IDX_SLIP, 32'h0);
    rd_chk("zero_high", `PM_IDX_ZERO_HIGH, 32'h0);
    rd_chk("zero_low", `PM_IDX_ZERO_LOW, 32'h0);
    rd_chk("mask", `PM_IDX_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 14'h0001, 32'h0);
    // interrupt masked, unmasked, cleared by status read
    ev(ev_rep, 1);
    irq_chk(1'b0);
    rd_chk("status", `PM_IDX_IRQ_STATUS, 32'h2);
    wr(`PM_IDX_IRQ_MASK, 4'h0, 32'h2);
    rd_chk("mask_nosel", `PM_IDX_IRQ_MASK, 32'h0);
    wr(`PM_IDX_IRQ_MASK, 4'h1, 32'h2);
    rd_chk("mask", `PM_IDX_IRQ_MASK, 32'h2);
    ev(ev_drop, 1);
    irq_chk(1'b1);
    rd_chk("status", `PM_IDX_IRQ_STATUS, 32'h2);
    irq_chk(1'b0);
    // slip: write ignored, repeat and drop in one cycle count twice
    wr(`PM_IDX_SLIP, 4'hf, 32'h55);
    ev(ev_rep, 3);
    ev(ev_drop, 2);
    ev(ev_rep | ev_drop, 1);
    rd_chk("slip", `PM_IDX_SLIP, 32'h9);
    rd_chk("slip_cleared", `PM_IDX_SLIP, 32'h0);
    // prbs: events straddling the high read are kept, low comes from capture
    ev(ev_prbs, 300);
    @(posedge clk_i);
    events_i <= ev_prbs;
    rd_chk("prbs_high", `PM_IDX_PRBS_HIGH, 32'h1);
    events_i <= '0;
    ev(ev_zero, 4);
    rd_chk("prbs_low", `PM_IDX_PRBS_LOW, 32'h2d);
    rd_chk("prbs_high", `PM_IDX_PRBS_HIGH, 32'h0);
    rd_chk("prbs_low", `PM_IDX_PRBS_LOW, 32'h2);
    rd_chk("prbs_low_cleared", `PM_IDX_PRBS_LOW, 32'h0);
    // zero violations, cleared by high then low read
    ev(ev_zero, 261);
    rd_chk("zero_high", `PM_IDX_ZERO_HIGH, 32'h1);
    rd_chk("zero_low", `PM_IDX_ZERO_LOW, 32'h9);
    rd_chk("zero_high_cleared", `PM_IDX_ZERO_HIGH, 32'h0);
    rd_chk("zero_low_cleared", `PM_IDX_ZERO_LOW, 32'h0);
    // saturation instead of wrap; one long run fills both 16-bit counters
    ev(ev_rep, 260);
    rd_chk("slip_sat", `PM_IDX_SLIP, 32'hff);
    ev(ev_zero | ev_prbs, 65540);
    rd_chk("prbs_high_sat", `PM_IDX_PRBS_HIGH, 32'hff);
    rd_chk("prbs_low_sat", `PM_IDX_PRBS_LOW, 32'hff);
    // a violation during the high read starts the next count
    @(posedge clk_i);
    events_i <= ev_zero;
    rd_chk("zero_high_sat", `PM_IDX_ZERO_HIGH, 32'hff);
    events_i <= '0;
    rd_chk("zero_low_sat", `PM_IDX_ZERO_LOW, 32'hff);
    rd_chk("zero_high_kept", `PM_IDX_ZERO_HIGH, 32'h0);
    rd_chk("zero_low_kept", `PM_IDX_ZERO_LOW, 32'h2);
    // every event kind left its sticky bit; only slip is unmasked
    irq_chk(1'b1);
    rd_chk("status_all", `PM_IDX_IRQ_STATUS, 32'h7);
    irq_chk(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
